// [hdl/split_desc_defs.vh]
// Field positions, limits and codes for split transfer descriptors
`ifndef SPLIT_DESC_DEFS_VH
`define SPLIT_DESC_DEFS_VH

// First doubleword (shared by bulk/control and isochronous forms)
`define DW0_EP_LSB_BIT      31
`define DW0_MAXLEN_HI       28
`define DW0_MAXLEN_LO       18
`define DW0_COUNT_HI        17
`define DW0_COUNT_LO        3
`define DW0_ACTIVE_BIT      0

// Second doubleword, bit positions counted from bit 0 of that word itself
`define DW1_SPEED_HI        17
`define DW1_SPEED_LO        16
`define DW1_EP_HI           2
`define DW1_EP_LO           0

// Speed codes, high bit first
`define SPEED_LOW           2'h2
`define SPEED_FULL          2'h0

// Payload and byte count limits at full speed
`define FS_MAX_PAYLOAD      11'h040
`define FS_ISO_MAX_COUNT    15'h0400

// Fourth doubleword: start-split mask and per-microframe results
`define DW4_SS_MASK_HI      7
`define DW4_SS_MASK_LO      0
`define DW4_STATUS_BASE     8
`define STATUS_W            3

// Fifth doubleword: complete-split mask and first received counts
`define DW5_CS_MASK_HI      7
`define DW5_CS_MASK_LO      0

// Widths
`define MAXLEN_W            11
`define COUNT_W             15
`define UFRAMES             8
`define RXCNT_W             8

`endif

// [hdl/desc_word0_decode.v]
// Field decode and limit check of the first descriptor doubleword
`timescale 1ns/1ps
`include "split_desc_defs.vh"

module desc_word0_decode (
  // Raw words
  input  wire [31:0]              word0,
  input  wire [31:0]              word1,
  input  wire                     iso_form,
  // Decoded fields
  output wire [3:0]               endpoint_number,
  output wire [`MAXLEN_W-1:0]     max_payload_len,
  output wire [`COUNT_W-1:0]      transfer_byte_count,
  output wire                     active,
  output wire [1:0]               split_speed_code,
  output wire                     low_speed,
  output wire                     field_error
);

  wire speed_bad;
  wire len_bad;
  wire count_bad;

  assign endpoint_number     = {word1[`DW1_EP_HI:`DW1_EP_LO], word0[`DW0_EP_LSB_BIT]};
  assign max_payload_len     = word0[`DW0_MAXLEN_HI:`DW0_MAXLEN_LO];
  assign transfer_byte_count = word0[`DW0_COUNT_HI:`DW0_COUNT_LO];
  assign active              = word0[`DW0_ACTIVE_BIT];
  assign split_speed_code    = word1[`DW1_SPEED_HI:`DW1_SPEED_LO];

  assign low_speed = (split_speed_code == `SPEED_LOW);
  // Iso form carries no speed code here, so only bulk/control is checked
  assign speed_bad = !iso_form && (split_speed_code != `SPEED_LOW) &&
                     (split_speed_code != `SPEED_FULL);
  assign len_bad   = !low_speed && (max_payload_len > `FS_MAX_PAYLOAD);
  assign count_bad = iso_form && (transfer_byte_count > `FS_ISO_MAX_COUNT);

  assign field_error = speed_bad | len_bad | count_bad;

endmodule // desc_word0_decode

// [hdl/split_descriptor_unit.v]
// Split transfer descriptor holder: decode, execution status and write-back
`timescale 1ns/1ps
`include "split_desc_defs.vh"

// Operating notes
//
// Load path
// - One strobe captures all four loaded words of a descriptor
// - Decode is combinational, capture is registered
// - Fields appear one cycle after the strobe
// - Fields hold until the next strobe or reset
// - Back to back strobes are fine
// - A strobe beats any engine event in its cycle
//
// Refusals
// - Cleared active bit: never requested
// - Bad speed code on bulk/control: flagged as error
// - Oversize payload above low speed: flagged as error
// - Oversize iso byte count: flagged as error
// - A refused descriptor counts as a fatal end
// - Error flag only set when the active bit was set
//
// Engine side
// - Request stays high while descriptor is active
// - Done or fatal ends it in the following cycle
// - Fatal end leaves the error flag set
// - Events while idle are ignored
//
// Microframe side
// - Results accepted only for an active iso descriptor
// - Status stored only where start split was armed
// - Received counts stored only for inbound transfers
// - Complete-split bit drops once its split is done
// - Outbound loads never arm complete splits
// - Results survive the end of the descriptor
//
// Write-back image
// - First word returns loaded bits with live active bit
// - Fourth word: start mask low, results above
// - Fifth word: complete mask low, counts 0 to 2 above
// - Sixth word: counts 3 to 6
// - Seventh word: count 7, upper bits zero
// - Image is combinational from the registers
//
// Limitations
// - Only words 0, 1, 4 and 5 are loaded
// - Reserved load bits pass through to write-back
// - No frame number check on microframe results
// - Speed check skipped for iso, no code there
// - Payload limit also applies to iso targets
//

module split_descriptor_unit (
  // Clock and reset
  input  wire                     CLK,
  input  wire                     SRST,
  // Descriptor load from shared memory
  input  wire                     LOAD_VALID,
  input  wire                     LOAD_ISO,
  input  wire                     LOAD_IN_DIR,
  input  wire [31:0]              LOAD_DW0,
  input  wire [31:0]              LOAD_DW1,
  input  wire [31:0]              LOAD_DW4,
  input  wire [31:0]              LOAD_DW5,
  // Execution engine events
  input  wire                     EXEC_DONE,
  input  wire                     EXEC_FATAL,
  input  wire                     UF_VALID,
  input  wire [2:0]               UF_INDEX,
  input  wire [`STATUS_W-1:0]     UF_STATUS,
  input  wire [`RXCNT_W-1:0]      UF_RX_BYTES,
  input  wire                     UF_CS_DONE,
  // Decoded view
  output wire                     EXEC_REQ,
  output reg  [3:0]               ENDPOINT_NUMBER,
  output reg  [`MAXLEN_W-1:0]     MAX_PAYLOAD_LEN,
  output reg  [`COUNT_W-1:0]      TRANSFER_BYTE_COUNT,
  output reg                      LOW_SPEED,
  output reg                      DESC_ERROR,
  output wire [`UFRAMES-1:0]      START_SPLIT_MASK,
  output wire [`UFRAMES-1:0]      COMPLETE_SPLIT_MASK,
  // Write-back image
  output wire [31:0]              WB_DW0,
  output wire [31:0]              WB_DW4,
  output wire [31:0]              WB_DW5,
  output wire [31:0]              WB_DW6,
  output wire [31:0]              WB_DW7
);

  reg  [31:0]                     dw0_q;
  reg                             active_q;
  reg                             iso_q;
  reg                             in_dir_q;
  reg  [`UFRAMES-1:0]             ss_mask_q;
  reg  [`UFRAMES-1:0]             cs_mask_q;
  reg  [`UFRAMES*`STATUS_W-1:0]   status_q;
  reg  [`UFRAMES*`RXCNT_W-1:0]    rx_bytes_q;

  wire [3:0]                      dec_ep;
  wire [`MAXLEN_W-1:0]            dec_len;
  wire [`COUNT_W-1:0]             dec_count;
  wire                            dec_active;
  wire                            dec_low;
  wire                            dec_error;

  // Combinational decode of the incoming words
  desc_word0_decode u_dec (
    .word0               (LOAD_DW0),
    .word1               (LOAD_DW1),
    .iso_form            (LOAD_ISO),
    .endpoint_number     (dec_ep),
    .max_payload_len     (dec_len),
    .transfer_byte_count (dec_count),
    .active              (dec_active),
    .split_speed_code    (),
    .low_speed           (dec_low),
    .field_error         (dec_error)
  );

  // Descriptor fields, latched on load
  always @(posedge CLK) begin
    if (SRST) begin
      dw0_q               <= 32'h00000000;
      iso_q               <= 1'b0;
      in_dir_q            <= 1'b0;
      ENDPOINT_NUMBER     <= 4'h0;
      MAX_PAYLOAD_LEN     <= {`MAXLEN_W{1'b0}};
      TRANSFER_BYTE_COUNT <= {`COUNT_W{1'b0}};
      LOW_SPEED           <= 1'b0;
    end else if (LOAD_VALID) begin
      dw0_q               <= LOAD_DW0;
      iso_q               <= LOAD_ISO;
      in_dir_q            <= LOAD_IN_DIR;
      ENDPOINT_NUMBER     <= dec_ep;
      MAX_PAYLOAD_LEN     <= dec_len;
      TRANSFER_BYTE_COUNT <= dec_count;
      LOW_SPEED           <= dec_low;
    end
  end

  // Active flag; a bad field set counts as fatal, so it never starts
  always @(posedge CLK) begin
    if (SRST) begin
      active_q   <= 1'b0;
      DESC_ERROR <= 1'b0;
    end else if (LOAD_VALID) begin
      active_q   <= dec_active & ~dec_error;
      DESC_ERROR <= dec_active & dec_error;
    end else if (active_q && (EXEC_DONE || EXEC_FATAL)) begin
      active_q   <= 1'b0;
      DESC_ERROR <= EXEC_FATAL;
    end
  end

  assign EXEC_REQ = active_q;

  // Per-microframe masks, status and received counts
  genvar g;
  generate
    for (g = 0; g < `UFRAMES; g = g + 1) begin : g_uframe
      wire hit;
      assign hit = active_q && iso_q && UF_VALID && (UF_INDEX == g);

      always @(posedge CLK) begin
        if (SRST) begin
          ss_mask_q[g]                           <= 1'b0;
          cs_mask_q[g]                           <= 1'b0;
          status_q[g*`STATUS_W +: `STATUS_W]     <= {`STATUS_W{1'b0}};
          rx_bytes_q[g*`RXCNT_W +: `RXCNT_W]     <= {`RXCNT_W{1'b0}};
        end else if (LOAD_VALID) begin
          // A new descriptor overrides any event in the same cycle
          ss_mask_q[g]                           <= LOAD_ISO & LOAD_DW4[`DW4_SS_MASK_LO + g];
          cs_mask_q[g]                           <= LOAD_ISO & LOAD_IN_DIR &
                                                    LOAD_DW5[`DW5_CS_MASK_LO + g];
          status_q[g*`STATUS_W +: `STATUS_W]     <= {`STATUS_W{1'b0}};
          rx_bytes_q[g*`RXCNT_W +: `RXCNT_W]     <= {`RXCNT_W{1'b0}};
        end else if (hit) begin
          if (ss_mask_q[g]) begin
            status_q[g*`STATUS_W +: `STATUS_W]   <= UF_STATUS;
          end
          if (ss_mask_q[g] && in_dir_q) begin
            rx_bytes_q[g*`RXCNT_W +: `RXCNT_W]   <= UF_RX_BYTES;
          end
          if (UF_CS_DONE) begin
            cs_mask_q[g]                         <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign START_SPLIT_MASK    = ss_mask_q;
  assign COMPLETE_SPLIT_MASK = cs_mask_q;

  assign WB_DW0 = {dw0_q[31:1], active_q};
  // Iso image words four to seven
  assign WB_DW4 = {status_q, ss_mask_q};
  assign WB_DW5 = {rx_bytes_q[3*`RXCNT_W-1:0], cs_mask_q};
  assign WB_DW6 = rx_bytes_q[7*`RXCNT_W-1:3*`RXCNT_W];
  // Upper bits of the last word are reserved, read as zero
  assign WB_DW7 = {24'h000000, rx_bytes_q[8*`RXCNT_W-1:7*`RXCNT_W]};

endmodule // split_descriptor_unit

// [verif/tt_engine_model.sv]
// Behavioural execution engine standing in for the hub translator side
`timescale 1ns/1ps
module tt_engine_model (
  // Clock and bench control
  input  wire       clk,
  input  wire       run,
  input  wire       fail,
  input  wire [3:0] lat,
  // Request in, completion out
  input  wire       req,
  output reg        done,
  output reg        fatal
);
  reg [3:0] wait_q;
  wire      busy = run && req && !done && !fatal;
  initial {done, fatal, wait_q} = 6'h00;
  // only active work is run, ended after lat cycles or fatally on demand
  always @(negedge clk) begin
    done   <= 1'b0;
    fatal  <= 1'b0;
    wait_q <= busy ? wait_q + 4'h1 : 4'h0;
    if (busy && wait_q == lat) begin
      done  <= !fail;
      fatal <= fail;
    end
  end
endmodule // tt_engine_model

// [verif/split_desc_checker_asserts.sv]
// Port-level assertions for the split descriptor unit
`timescale 1ns/1ps
module split_desc_checker (
  // Clock, reset and stimulus
  input wire        CLK,
  input wire        SRST,
  input wire        LOAD_VALID,
  input wire        LOAD_ISO,
  input wire [31:0] LOAD_DW0,
  input wire [31:0] LOAD_DW1,
  input wire        EXEC_DONE,
  input wire        EXEC_FATAL,
  // Watched outputs
  input wire        EXEC_REQ,
  input wire [3:0]  ENDPOINT_NUMBER,
  input wire [10:0] MAX_PAYLOAD_LEN,
  input wire [14:0] TRANSFER_BYTE_COUNT,
  input wire        LOW_SPEED,
  input wire        DESC_ERROR,
  input wire [31:0] WB_DW0
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // Clean full-speed bulk load that must be accepted
  wire full_ok = !LOAD_ISO && LOAD_DW1[17:16] == 2'h0 && LOAD_DW0[28:18] <= 11'h040;
  wire quiet   = !LOAD_VALID && !EXEC_DONE && !EXEC_FATAL;
  a_load_activates: assert property (LOAD_VALID && LOAD_DW0[0] && full_ok |=> EXEC_REQ)
    else $error("valid load not active");
  a_inactive_load: assert property (LOAD_VALID && !LOAD_DW0[0] |=> !EXEC_REQ)
    else $error("inactive load went active");
  a_done_clears: assert property (EXEC_REQ && EXEC_DONE && !LOAD_VALID |=> !WB_DW0[0])
    else $error("active bit kept after done");
  a_fatal_flags: assert property (EXEC_REQ && EXEC_FATAL && !LOAD_VALID |=> DESC_ERROR && !EXEC_REQ)
    else $error("fatal end not flagged");
  a_active_holds: assert property (EXEC_REQ && quiet |=> $stable(EXEC_REQ))
    else $error("active dropped early");
  a_fields_latch: assert property (LOAD_VALID |=> MAX_PAYLOAD_LEN == $past(LOAD_DW0[28:18])
    && TRANSFER_BYTE_COUNT == $past(LOAD_DW0[17:3]))
    else $error("length fields wrong");
  a_endpoint_bits: assert property (LOAD_VALID |=>
    ENDPOINT_NUMBER == {$past(LOAD_DW1[2:0]), $past(LOAD_DW0[31])})
    else $error("endpoint wrong");
  a_speed_code: assert property (LOAD_VALID && !LOAD_ISO |=> LOW_SPEED == ($past(LOAD_DW1[17:16]) == 2'h2)
    && (!$past(LOAD_DW1[16]) || DESC_ERROR == $past(LOAD_DW0[0]) && !EXEC_REQ))
    else $error("speed code handling wrong");
  a_iso_limit: assert property (LOAD_VALID && LOAD_ISO && LOAD_DW0[17:3] > 15'h0400 |=>
    DESC_ERROR == $past(LOAD_DW0[0]) && !EXEC_REQ)
    else $error("iso count limit missed");
endmodule // split_desc_checker

bind split_descriptor_unit split_desc_checker chk (.*);

// [verif/tb_split_descriptor_unit.sv]
// Self-checking testbench for the split descriptor unit
`timescale 1ns/1ps
module tb_split_descriptor_unit;
  reg         CLK, SRST, LOAD_VALID, LOAD_ISO, LOAD_IN_DIR, UF_VALID, UF_CS_DONE, run, fail;
  reg  [31:0] LOAD_DW0, LOAD_DW1, LOAD_DW4, LOAD_DW5;
  reg  [2:0]  UF_INDEX, UF_STATUS;
  reg  [7:0]  UF_RX_BYTES;
  reg  [3:0]  lat;
  wire        EXEC_DONE, EXEC_FATAL, EXEC_REQ, LOW_SPEED, DESC_ERROR;
  wire [3:0]  ENDPOINT_NUMBER;
  wire [10:0] MAX_PAYLOAD_LEN;
  wire [14:0] TRANSFER_BYTE_COUNT;
  wire [7:0]  START_SPLIT_MASK, COMPLETE_SPLIT_MASK;
  wire [31:0] WB_DW0, WB_DW4, WB_DW5, WB_DW6, WB_DW7;
  integer     fails, total_checks, i;
  split_descriptor_unit dut (.*);
  tt_engine_model eng (.clk(CLK), .run(run), .fail(fail), .lat(lat), .req(EXEC_REQ),
    .done(EXEC_DONE), .fatal(EXEC_FATAL));
  // Clock, 5 ns period
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  task chk(input [63:0] got, input [63:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // First doubleword image from its fields
  function [31:0] w0(input e, input [10:0] len, input [14:0] cnt, input v);
    w0 = {e, 2'b00, len, cnt, 2'b00, v};
  endfunction
  // One-cycle load strobe, entered and left at a falling edge
  task load(input iso, input dir, input [31:0] d0, input [31:0] d1, input [31:0] d4,
            input [31:0] d5);
    begin
      {LOAD_ISO, LOAD_IN_DIR, LOAD_DW0, LOAD_DW1, LOAD_DW4, LOAD_DW5} = {iso, dir, d0, d1, d4, d5};
      LOAD_VALID = 1'b1;
      @(negedge CLK) LOAD_VALID = 1'b0;
    end
  endtask
  task uf(input [2:0] idx, input [2:0] st, input [7:0] rx, input cs);
    begin
      {UF_INDEX, UF_STATUS, UF_RX_BYTES, UF_CS_DONE, UF_VALID} = {idx, st, rx, cs, 1'b1};
      @(negedge CLK) UF_VALID = 1'b0;
    end
  endtask
  // Bounded wait for the engine to end the descriptor
  task wait_idle;
    for (i = 0; i < 30 && EXEC_REQ !== 1'b0; i = i + 1) @(negedge CLK);
  endtask
  task results;
    begin
      $display("Checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  // Watchdog well beyond the few dozen cycles the tests need
  initial begin
    #20000 fails = fails + 1;
    results;
  end
  initial begin
    {SRST, LOAD_VALID, LOAD_ISO, LOAD_IN_DIR, UF_VALID, UF_CS_DONE, run, fail} = 8'h80;
    {LOAD_DW0, LOAD_DW1, LOAD_DW4, LOAD_DW5, UF_INDEX, UF_STATUS, UF_RX_BYTES, lat} = 0;
    {fails, total_checks} = 0;
    repeat (3) @(negedge CLK);
    SRST = 1'b0;
    chk({EXEC_REQ, DESC_ERROR, WB_DW0}, 0);
    run = 1'b1;
    lat = 4'h5;
    load(0, 0, w0(1, 11'h040, 15'h0123, 1), 32'h5, 0, 0);
    chk({EXEC_REQ, ENDPOINT_NUMBER, MAX_PAYLOAD_LEN, TRANSFER_BYTE_COUNT}, {1'b1, 4'hB, 11'h040, 15'h0123});
    wait_idle;
    chk({EXEC_REQ, WB_DW0[0], DESC_ERROR}, 0);
    $display("Test bulk full speed done");
    {fail, lat} = 5'h10;
    load(0, 0, w0(0, 11'h041, 15'h0010, 1), 32'h0002_0000, 0, 0);
    chk({EXEC_REQ, LOW_SPEED}, 2'b11);
    wait_idle;
    chk({EXEC_REQ, DESC_ERROR}, 2'b01);
    {run, fail} = 2'b00;
    load(0, 0, w0(0, 11'h041, 15'h0010, 1), 0, 0, 0);
    chk({EXEC_REQ, DESC_ERROR}, 2'b01);
    for (i = 1; i < 4; i = i + 2) begin
      load(0, 0, w0(0, 11'h008, 15'h0010, 1), i << 16, 0, 0);
      chk({EXEC_REQ, DESC_ERROR}, 2'b01);
    end
    load(0, 0, w0(0, 11'h008, 15'h0010, 0), 0, 0, 0);
    chk(EXEC_REQ, 0);
    $display("Test refusals done");
    load(1, 1, w0(0, 11'h040, 15'h0400, 1), 0, 32'h85, 32'h85);
    chk(EXEC_REQ, 1);
    uf(0, 3'h5, 8'hA5, 1);
    uf(1, 3'h7, 8'h11, 0);
    uf(2, 3'h2, 8'h3C, 0);
    uf(7, 3'h1, 8'h77, 0);
    run = 1'b1;
    wait_idle;
    chk(WB_DW4, 32'h2000_8585);
    chk({WB_DW5, START_SPLIT_MASK, COMPLETE_SPLIT_MASK}, {32'h3C00_A584, 16'h8584});
    chk({WB_DW6, WB_DW7}, 64'h77);
    run = 1'b0;
    load(1, 0, w0(0, 11'h040, 15'h0401, 1), 0, 0, 0);
    chk({EXEC_REQ, DESC_ERROR}, 2'b01);
    load(1, 0, w0(0, 11'h040, 15'h0400, 1), 0, 32'h1, 32'hFF);
    chk(COMPLETE_SPLIT_MASK, 0);
    $display("Test isochronous done");
    results;
  end
endmodule // tb_split_descriptor_unit
